/* dv/clc_src_model.sv */
// Far-side source model: pins and peripheral outputs feeding the cell
`timescale 1ns/100ps
module clc_src_model (
  input wire logic pclk, // Clock
  input wire logic [63:0] level, // Levels by source number
  output logic data_input_a, // Source 0
  output logic data_input_b, // Source 1
  output logic data_input_c, // Source 2
  output logic data_input_d, // Source 3
  output logic [59:0] periph_src // Sources 4 and up
);
  // Sources move only after an edge, like same-clock peripherals
  initial begin
    {periph_src, data_input_d, data_input_c, data_input_b, data_input_a} = 64'h0;
    forever begin
      @(posedge pclk);
      {periph_src, data_input_d, data_input_c, data_input_b, data_input_a} <= level;
    end
  end
endmodule

/* dv/clc_top_assertions.sv */
// Port-level checks of the logic cell: bus answer, read-back, enable and edge interrupt
`timescale 1ns/100ps
`include "clc_consts.svh"
module clc_top_assertions (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic clk_en, // Enable
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [`CLC_ADDR_W-1:0] paddr, // Address
  input wire logic [31:0] pwdata, // Wdata
  input wire logic [3:0] pstrb, // Strobes
  input wire logic [31:0] prdata, // Rdata
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic cell_output, // Output
  input wire logic irq // Interrupt
);
  logic wr_ok;
  logic en_q, rise_q, fall_q, mask_q;
  assign wr_ok = psel && penable && pwrite && pready && pstrb[0];
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the enable bits, taken from completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {en_q, rise_q, fall_q, mask_q} <= 4'h0;
    end else if (wr_ok && paddr == `CLC_OFF_CONTROL) begin
      {en_q, rise_q, fall_q} <= {pwdata[7], pwdata[4:3]};
    end else if (wr_ok && paddr == `CLC_OFF_IRQ_MASK) begin
      mask_q <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  ready_follow_a: assert property (pready == clk_en)
    else $error("pready differs from clk_en");
  unmapped_err_a: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `CLC_OFF_IRQ_MASK)) else $error("pslverr wrong for address");
  err_read_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  ctl_unused_a: assert property (psel && penable && !pwrite && paddr == `CLC_OFF_CONTROL
    |-> {prdata[31:8], prdata[6]} == 25'h0) else $error("unused control bits not zero");
  out_status_a: assert property (psel && !penable && !pwrite && clk_en &&
    paddr == `CLC_OFF_CONTROL |=> prdata[5] == $past(cell_output))
    else $error("status bit differs from output");
  off_quiet_a: assert property (!en_q && clk_en |=> !cell_output)
    else $error("disabled cell drives one");
  mask_quiet_a: assert property (!mask_q |-> !irq) else $error("masked interrupt raised");
  rise_flag_a: assert property (rise_q && mask_q && clk_en && $rose(cell_output) |=> irq)
    else $error("rising edge missed");
  fall_flag_a: assert property (fall_q && mask_q && clk_en && $fell(cell_output) |=> irq)
    else $error("falling edge missed");
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the configurable logic cell
`timescale 1ns/100ps
`include "clc_consts.svh"
module tb_top;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, cell_output, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, strb;
  logic a_in, b_in, c_in, d_in;
  logic [59:0] periph_src;
  logic [63:0] level;
  logic [31:0] exp_q[$];
  int num_errors, samples_checked;
  clc_top u_clc_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_input_a(a_in),
    .data_input_b(b_in), .data_input_c(c_in), .data_input_d(d_in),
    .periph_src(periph_src), .cell_output(cell_output), .irq(irq));
  clc_src_model u_clc_src_model (.pclk(pclk), .level(level), .data_input_a(a_in),
    .data_input_b(b_in), .data_input_c(c_in), .data_input_d(d_in), .periph_src(periph_src));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    num_errors++;
    $display("Error %0t: %s", $time, msg);
  endtask
  task automatic chk(input logic got, input logic e, input string msg);
    samples_checked++;
    if (got !== e) fail(msg);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail("no pready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    apb(1'b0, a, 8'h00);
  endtask
  // Read results are judged here, in order of issue
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      samples_checked++;
      if (exp_q.size() == 0) fail("unexpected read");
      else if (prdata !== exp_q.pop_front()) fail("read data mismatch");
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic gate_val(input logic [7:0] r, input logic [3:0] d);
    gate_val = (r != 8'h00);
    for (int k = 0; k < 4; k++) begin
      if (r[2*k+1]) gate_val &= d[k];
      if (r[2*k]) gate_val &= ~d[k];
    end
  endfunction
  function automatic logic next_q(input int m, input logic [3:0] g, input logic [3:0] gp,
    input logic q);
    logic up;
    up = g[0] & ~gp[0];
    case (m)
      3: next_q = (g[2] | g[3]) ? 1'b0 : ((g[0] | g[1]) ? 1'b1 : q);
      4: next_q = g[2] ? 1'b0 : (g[3] ? 1'b1 : (up ? g[1] : q));
      5: next_q = g[2] ? 1'b0 : (up ? g[1] & g[3] : q);
      6: next_q = g[2] ? 1'b0 : (up ? (g[1] & ~q | ~g[3] & q) : q);
      default: next_q = g[0] ? 1'b0 : (g[3] ? 1'b1 : (g[2] ? g[1] : q));
    endcase
  endfunction
  task automatic comb_test;
    logic [63:0] v;
    logic [5:0] s;
    logic [7:0] r[4];
    logic [7:0] p;
    logic [3:0] d, g;
    logic f;
    for (int i = 0; i < 24; i++) begin
      v = {$urandom, $urandom};
      level <= v;
      p = $urandom;
      wr(`CLC_OFF_POLARITY, p);
      for (int k = 0; k < 4; k++) begin
        s = $urandom;
        r[k] = $urandom;
        d[k] = v[s];
        wr(`CLC_OFF_SEL0 + 12'(4 * k), {2'b11, s});
        rd(`CLC_OFF_SEL0 + 12'(4 * k), {2'b00, s});
        wr(`CLC_OFF_ROUTE0 + 12'(4 * k), r[k]);
      end
      for (int k = 0; k < 4; k++) g[k] = gate_val(r[k], d) ^ p[k];
      case (i % 3)
        0: f = (g[0] & g[1]) | (g[2] & g[3]);
        1: f = (g[0] | g[1]) ^ (g[2] | g[3]);
        default: f = &g;
      endcase
      wr(`CLC_OFF_CONTROL, 8'h80 | 8'(i % 3));
      repeat (6) @(posedge pclk);
      chk(cell_output, f ^ p[7], "function output");
      rd(`CLC_OFF_CONTROL, {2'b10, f ^ p[7], 2'b00, 3'(i % 3)});
    end
  endtask
  task automatic seq_test;
    logic [7:0] p;
    logic [3:0] gp;
    logic q;
    for (int k = 0; k < 4; k++) wr(`CLC_OFF_ROUTE0 + 12'(4 * k), 8'h00);
    for (int m = 3; m < 8; m++) begin
      wr(`CLC_OFF_CONTROL, 8'h00);
      wr(`CLC_OFF_POLARITY, 8'h00);
      wr(`CLC_OFF_CONTROL, 8'h80 | 8'(m));
      q = 1'b0;
      gp = 4'h0;
      for (int i = 0; i < 16; i++) begin
        p = $urandom;
        q = next_q(m, p[3:0], gp, q);
        gp = p[3:0];
        wr(`CLC_OFF_POLARITY, p);
        repeat (3) @(posedge pclk);
        chk(cell_output, q ^ p[7], "storage output");
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    strb = 4'hF;
    level = 64'h0;
    void'($urandom(32'hAF5C));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CLC_OFF_CONTROL, 8'h00);
    wr(`CLC_OFF_POLARITY, 8'hFF);
    rd(`CLC_OFF_POLARITY, 8'h8F);
    wr(`CLC_OFF_ROUTE1, 8'hA5);
    rd(`CLC_OFF_ROUTE1, 8'hA5);
    wr(`CLC_OFF_CONTROL, 8'h7F);
    rd(`CLC_OFF_CONTROL, 8'h1F);
    chk(cell_output, 1'b0, "disabled output");
    strb = 4'hE;
    wr(`CLC_OFF_POLARITY, 8'h00);
    strb = 4'hF;
    rd(`CLC_OFF_POLARITY, 8'h8F);
    rd(12'h100, 8'h00);
    $display("register test done");
    comb_test();
    $display("function test done");
    seq_test();
    $display("storage test done");
    wr(`CLC_OFF_CONTROL, 8'h00);
    wr(`CLC_OFF_POLARITY, 8'h00);
    wr(`CLC_OFF_IRQ_MASK, 8'h01);
    for (int e = 0; e < 4; e++) begin
      wr(`CLC_OFF_CONTROL, 8'h82 | 8'(e << 3));
      wr(`CLC_OFF_POLARITY, 8'h0F);
      repeat (3) @(posedge pclk);
      chk(irq, e[1], "irq after rise");
      rd(`CLC_OFF_IRQ_STATUS, {7'h0, e[1]});
      chk(irq, 1'b0, "irq after clear");
      wr(`CLC_OFF_POLARITY, 8'h00);
      repeat (3) @(posedge pclk);
      chk(irq, e[0], "irq after fall");
      rd(`CLC_OFF_IRQ_STATUS, {7'h0, e[0]});
    end
    wr(`CLC_OFF_IRQ_MASK, 8'h00);
    wr(`CLC_OFF_POLARITY, 8'h0F);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0, "masked irq");
    rd(`CLC_OFF_IRQ_STATUS, 8'h01);
    $display("interrupt test done");
    wr(`CLC_OFF_POLARITY, 8'h8F);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CLC_OFF_CONTROL, 8'h00);
    fork
      rd(`CLC_OFF_POLARITY, 8'h0F);
      begin
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    $display("reset test done");
    stop_test();
  end
  initial begin
    #400000;
    fail("watchdog expired");
    stop_test();
  end
  task automatic stop_test;
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
endmodule
bind clc_top clc_top_assertions u_clc_top_assertions (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cell_output(cell_output), .irq(irq));

/* rtl/clc_consts.svh */
// Register offsets, field positions, reset values and sizes of the logic cell
`ifndef CLC_CONSTS_SVH
`define CLC_CONSTS_SVH

`define CLC_ADDR_W 12
`define CLC_OFF_CONTROL 12'h000
`define CLC_OFF_POLARITY 12'h004
`define CLC_OFF_SEL0 12'h008
`define CLC_OFF_SEL1 12'h00C
`define CLC_OFF_SEL2 12'h010
`define CLC_OFF_SEL3 12'h014
`define CLC_OFF_ROUTE0 12'h018
`define CLC_OFF_ROUTE1 12'h01C
`define CLC_OFF_ROUTE2 12'h020
`define CLC_OFF_ROUTE3 12'h024
`define CLC_OFF_IRQ_STATUS 12'h028
`define CLC_OFF_IRQ_MASK 12'h02C

`define CLC_CTL_EN_BIT 7
`define CLC_CTL_OUT_BIT 5
`define CLC_CTL_RISE_BIT 4
`define CLC_CTL_FALL_BIT 3
`define CLC_CTL_MODE_MSB 2
`define CLC_CTL_MODE_LSB 0
`define CLC_CTL_WMASK 8'h9F
`define CLC_CTL_RESET 8'h00

`define CLC_POL_OUT_BIT 7
`define CLC_POL_WMASK 8'h8F
`define CLC_SEL_WMASK 8'h3F
`define CLC_SEL_W 6

`define CLC_IRQ_EDGE_BIT 0
`define CLC_IRQ_W 1
`define CLC_IRQ_RESET 1'h0

`define CLC_NUM_PINS 4
`define CLC_NUM_GATES 4

`endif

/* rtl/clc_logic_func.sv */
// Logic function stage: three combinational and five storage functions of four gates
`timescale 1ns/100ps
module clc_logic_func
  import clc_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic cell_on, // Cell enabled; storage held clear while off
  input clc_mode_e mode, // Selected function
  input wire logic [3:0] gate, // Gate outputs after gate polarity
  output logic func_out // Function result before output inversion
);

  logic state_q;
  logic state_d;
  logic clk_gate_q;
  logic clk_rise;
  logic set_in;
  logic rst_in;

  // Flip-flop functions clock on gate 0 rising, seen on pclk
  assign clk_rise = gate[0] & ~clk_gate_q;

  always_comb begin
    state_d = state_q;
    set_in = 1'b0;
    rst_in = 1'b0;
    unique case (mode)
      CLC_SR_LATCH: begin
        set_in = gate[0] | gate[1];
        rst_in = gate[2] | gate[3];
        if (set_in) state_d = 1'b1;
      end
      CLC_DFF_SR: begin
        set_in = gate[3];
        rst_in = gate[2];
        if (set_in) state_d = 1'b1;
        else if (clk_rise) state_d = gate[1];
      end
      CLC_DFF2_R: begin
        rst_in = gate[2];
        if (clk_rise) state_d = gate[1] & gate[3];
      end
      CLC_JKFF_R: begin
        rst_in = gate[2];
        if (clk_rise) state_d = (gate[1] & ~state_q) | (~gate[3] & state_q);
      end
      CLC_DLATCH_SR: begin
        set_in = gate[3];
        rst_in = gate[0];
        if (set_in) state_d = 1'b1;
        else if (gate[2]) state_d = gate[1];
      end
      CLC_AND_OR, CLC_OR_XOR, CLC_AND4: begin
        state_d = 1'b0;
      end
    endcase
    // Reset dominates set in every storage function
    if (rst_in || !cell_on) state_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= 1'b0;
      clk_gate_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      clk_gate_q <= gate[0];
    end
  end

  always_comb begin
    unique case (mode)
      CLC_AND_OR: func_out = (gate[0] & gate[1]) | (gate[2] & gate[3]); // RQ6
      CLC_OR_XOR: func_out = (gate[0] | gate[1]) ^ (gate[2] | gate[3]); // RQ6
      CLC_AND4: func_out = &gate; // RQ6
      CLC_SR_LATCH, CLC_DFF_SR, CLC_DFF2_R, CLC_JKFF_R, CLC_DLATCH_SR: begin
        func_out = state_q; // RQ5
      end
    endcase
  end

endmodule

/* rtl/clc_pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module clc_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Clock enable
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
  output logic [WIDTH-1:0] pin_out // Filtered levels
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (clk_en) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a new level only once it has held for two samples
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out[i] <= 1'b0;
        end else if (clk_en && (s2_q[i] == s3_q[i])) begin
          pin_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule

/* rtl/clc_pkg.sv */
// Types shared by the logic cell modules
package clc_pkg;

  typedef enum logic [2:0] {
    CLC_AND_OR = 3'b000,
    CLC_OR_XOR = 3'b001,
    CLC_AND4 = 3'b010,
    CLC_SR_LATCH = 3'b011,
    CLC_DFF_SR = 3'b100,
    CLC_DFF2_R = 3'b101,
    CLC_JKFF_R = 3'b110,
    CLC_DLATCH_SR = 3'b111
  } clc_mode_e;

endpackage

/* rtl/clc_top.sv */
// Configurable logic cell with APB registers, input selection, gating and edge interrupt
//
// Overview of operation
// RQ1: With the enable bit clear the cell output is a constant zero; when set the cell works.
// RQ2: A read-only control bit returns the cell output taken after output inversion.
// RQ3: With rising-edge enable set, every low-to-high output change sets the edge flag.
// RQ4: With falling-edge enable set, every high-to-low output change sets the edge flag.
// RQ5: Function codes 111 to 011 select latch, J-K, two D flip-flops and S-R latch.
// RQ6: Function codes 010, 001 and 000 select four-input AND, OR-XOR and AND-OR.
// RQ7: Each of four low polarity bits inverts its gate output before the function stage.
// RQ8: Each data input is chosen by its own six-bit source field in its own register.
// RQ9: Each gate route register has true and inverted enables per input, input d at the top.
// RQ10: Unimplemented register bits ignore writes and read as zero.
// RQ11: The output polarity bit inverts the function result before it becomes the output.
// RQ12: Reset clears the control register while selection, routing and polarity keep values; the code also clears the output polarity bit.
// RQ13: Software clears the edge flag, and an edge during the clear leaves it set.
// RQ14: A gate is the AND of all forms routed into it, a constant when nothing is routed.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "clc_consts.svh"

module clc_top
  import clc_pkg::*;
#(
  parameter int NUM_SRC = 64, // Source count reachable by a six-bit select
  parameter int NUM_PERIPH = 60 // On-chip sources above the four pins
) (
  input wire logic pclk, // APB clock, 125 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [`CLC_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic data_input_a, // Pin source 0
  input wire logic data_input_b, // Pin source 1
  input wire logic data_input_c, // Pin source 2
  input wire logic data_input_d, // Pin source 3
  input wire logic [NUM_PERIPH-1:0] periph_src, // Same-clock peripheral sources 4 and up
  output logic cell_output, // Cell output
  output logic irq // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] control_q;
  logic [3:0] polarity_q;
  logic out_inv_q;
  logic [`CLC_SEL_W-1:0] sel_q [4];
  logic [7:0] route_q [`CLC_NUM_GATES];
  logic [`CLC_IRQ_W-1:0] irq_status_q;
  logic [`CLC_IRQ_W-1:0] irq_status_d;
  logic [`CLC_IRQ_W-1:0] irq_mask_q;
  logic [`CLC_IRQ_W-1:0] rd_seen_q;

  logic cell_out_q;
  logic cell_out_d;
  logic prev_out_q;
  logic rise_ev;
  logic fall_ev;
  logic edge_ev;

  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_done;
  logic addr_hit;
  logic [31:0] rd_val;
  logic [7:0] wbyte;
  logic ctl_wr;
  logic pol_wr;
  logic mask_wr;
  logic stat_rd;

  logic [3:0] pins_sync;
  logic [NUM_SRC-1:0] src_vec;
  logic [3:0] data_sel;
  logic [3:0] gate_raw;
  logic [3:0] gate_pol;
  logic func_out;
  clc_mode_e mode;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave

  // Zero wait states, but the transfer stalls while the clock enable is low
  assign pready = clk_en;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & clk_en;
  assign wr_en = access_ph & pwrite & pstrb[0] & addr_hit;
  assign rd_done = access_ph & ~pwrite;
  assign wbyte = pwdata[7:0];

  assign ctl_wr = wr_en & (paddr == `CLC_OFF_CONTROL);
  assign pol_wr = wr_en & (paddr == `CLC_OFF_POLARITY);
  assign mask_wr = wr_en & (paddr == `CLC_OFF_IRQ_MASK);
  assign stat_rd = rd_done & (paddr == `CLC_OFF_IRQ_STATUS);

  always_comb begin
    addr_hit = 1'b1;
    unique case (paddr)
      `CLC_OFF_CONTROL, `CLC_OFF_POLARITY, `CLC_OFF_SEL0, `CLC_OFF_SEL1,
      `CLC_OFF_SEL2, `CLC_OFF_SEL3, `CLC_OFF_ROUTE0, `CLC_OFF_ROUTE1,
      `CLC_OFF_ROUTE2, `CLC_OFF_ROUTE3, `CLC_OFF_IRQ_STATUS, `CLC_OFF_IRQ_MASK: begin
        addr_hit = 1'b1;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  assign pslverr = access_ph & ~addr_hit;

  always_comb begin
    rd_val = 32'h00000000;
    unique case (paddr)
      `CLC_OFF_CONTROL: begin
        rd_val[7:0] = control_q; // RQ2
      end
      `CLC_OFF_POLARITY: begin
        rd_val[7:0] = {out_inv_q, 3'h0, polarity_q}; // RQ10
      end
      `CLC_OFF_SEL0: begin
        rd_val[5:0] = sel_q[0];
      end
      `CLC_OFF_SEL1: begin
        rd_val[5:0] = sel_q[1];
      end
      `CLC_OFF_SEL2: begin
        rd_val[5:0] = sel_q[2];
      end
      `CLC_OFF_SEL3: begin
        rd_val[5:0] = sel_q[3];
      end
      `CLC_OFF_ROUTE0: begin
        rd_val[7:0] = route_q[0];
      end
      `CLC_OFF_ROUTE1: begin
        rd_val[7:0] = route_q[1];
      end
      `CLC_OFF_ROUTE2: begin
        rd_val[7:0] = route_q[2];
      end
      `CLC_OFF_ROUTE3: begin
        rd_val[7:0] = route_q[3];
      end
      `CLC_OFF_IRQ_STATUS: begin
        rd_val[`CLC_IRQ_W-1:0] = irq_status_q;
      end
      `CLC_OFF_IRQ_MASK: begin
        rd_val[`CLC_IRQ_W-1:0] = irq_mask_q;
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  // Read data is caught in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && setup_ph && !pwrite) begin
      prdata <= rd_val;
    end
  end

  // Status bits shown to the reader; only these are cleared when the read completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_seen_q <= '0;
    end else if (clk_en && setup_ph) begin
      rd_seen_q <= (!pwrite && paddr == `CLC_OFF_IRQ_STATUS) ? irq_status_q : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register: cleared by reset, like output inversion and the interrupt registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= `CLC_CTL_RESET; // RQ12
    end else if (clk_en) begin
      if (ctl_wr) begin
        control_q <= (wbyte & `CLC_CTL_WMASK) | (control_q & ~`CLC_CTL_WMASK); // RQ10
      end
      control_q[`CLC_CTL_OUT_BIT] <= cell_out_d; // RQ2
    end
  end

  // Gate polarity survives reset and is unknown at power-up
  always_ff @(posedge pclk) begin
    if (clk_en && pol_wr) begin
      polarity_q <= wbyte[3:0]; // RQ7
    end
  end

  // Output inversion is the one polarity bit that reset clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_inv_q <= 1'b0; // RQ12
    end else if (clk_en && pol_wr) begin
      out_inv_q <= wbyte[`CLC_POL_OUT_BIT]; // RQ11
    end
  end

  // Select and route registers survive reset and are unknown at power-up
  genvar r;
  generate
    for (r = 0; r < `CLC_NUM_GATES; r++) begin : g_cfg
      logic sel_wr;
      logic route_wr;

      assign sel_wr = wr_en & (paddr == (`CLC_OFF_SEL0 + 12'(4 * r)));
      assign route_wr = wr_en & (paddr == (`CLC_OFF_ROUTE0 + 12'(4 * r)));

      always_ff @(posedge pclk) begin
        if (clk_en && sel_wr) begin
          sel_q[r] <= wbyte[`CLC_SEL_W-1:0]; // RQ8
        end
      end

      // Both forms of one input may be routed; the gate then stays low
      always_ff @(posedge pclk) begin
        if (clk_en && route_wr) begin
          route_q[r] <= wbyte; // RQ9
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `CLC_IRQ_RESET;
    end else if (clk_en && mask_wr) begin
      irq_mask_q <= wbyte[`CLC_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input selection

  clc_pin_sync #(
    .WIDTH(`CLC_NUM_PINS)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in({data_input_d, data_input_c, data_input_b, data_input_a}),
    .pin_out(pins_sync)
  );

  // Peripheral sources share pclk, so they are used as they arrive
  assign src_vec = {periph_src, pins_sync};

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_sel
      assign data_sel[k] = src_vec[sel_q[k]]; // RQ8
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Data gating

  // Route bit 2k+1 passes input k true, bit 2k passes it inverted
  genvar g;
  generate
    for (g = 0; g < `CLC_NUM_GATES; g++) begin : g_gate
      logic [3:0] term;
      for (k = 0; k < 4; k++) begin : g_term
        assign term[k] = (~route_q[g][2*k+1] | data_sel[k]) // RQ9
                       & (~route_q[g][2*k] | ~data_sel[k]); // RQ9
      end
      // Empty route gives zero, so the polarity bit alone sets the level
      assign gate_raw[g] = (|route_q[g]) & (&term); // RQ14
      assign gate_pol[g] = gate_raw[g] ^ polarity_q[g]; // RQ7
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Logic function and output

  assign mode = clc_mode_e'(control_q[`CLC_CTL_MODE_MSB:`CLC_CTL_MODE_LSB]);

  clc_logic_func u_func (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .cell_on(control_q[`CLC_CTL_EN_BIT]),
    .mode(mode),
    .gate(gate_pol),
    .func_out(func_out)
  );

  always_comb begin
    cell_out_d = 1'b0; // RQ1
    if (control_q[`CLC_CTL_EN_BIT]) begin
      cell_out_d = func_out ^ out_inv_q; // RQ11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_out_q <= 1'b0;
      prev_out_q <= 1'b0;
    end else if (clk_en) begin
      cell_out_q <= cell_out_d; // RQ1
      prev_out_q <= cell_out_q;
    end
  end

  assign cell_output = cell_out_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Edge interrupt

  // Polarity changes also make edges here, which software must expect
  assign rise_ev = cell_out_q & ~prev_out_q & control_q[`CLC_CTL_RISE_BIT]; // RQ3
  assign fall_ev = ~cell_out_q & prev_out_q & control_q[`CLC_CTL_FALL_BIT]; // RQ4
  assign edge_ev = rise_ev | fall_ev;

  always_comb begin
    irq_status_d = irq_status_q;
    if (stat_rd) begin
      irq_status_d = irq_status_q & ~rd_seen_q;
    end
    // Set wins so an edge during the clearing read is kept
    irq_status_d[`CLC_IRQ_EDGE_BIT] = irq_status_d[`CLC_IRQ_EDGE_BIT] | edge_ev; // RQ13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= `CLC_IRQ_RESET;
    end else if (clk_en) begin
      irq_status_q <= irq_status_d;
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

endmodule
